// ==== inc/cat_regs.svh ====
// register map, field codes and reset values of the timer core
// assumes a 32-bit AXI4-Lite slave with 8-bit byte addresses
`ifndef CAT_REGS_SVH
`define CAT_REGS_SVH

`define CAT_ADDR_W 8
`define CAT_OFF_CTRL 8'h18
`define CAT_OFF_CAPTURE_RELOAD_VALUE 8'h1c
`define CAT_OFF_AUX 8'h2c
`define CAT_OFF_CORE 8'h30
`define CAT_OFF_STATUS 8'h38
`define CAT_OFF_MASK 8'h3c

`define CAT_RST_CTRL 16'h0000
`define CAT_CTRL_WMASK 16'hdfff
`define CAT_RST_CAPTURE_RELOAD_VALUE 16'h0000
`define CAT_RST_COUNT 16'h0000
`define CAT_COUNT_MAX 16'hffff

`define CAT_ST_CORE 0
`define CAT_ST_AUX 1
`define CAT_ST_CAP 2

`define CAT_MODE_TIMER 3'h0
`define CAT_MODE_COUNTER 3'h1
`define CAT_MODE_GATED_LOW 3'h2
`define CAT_MODE_GATED_HIGH 3'h3

`define CAT_EDGE_RISE 3'h1
`define CAT_EDGE_FALL 3'h2
`define CAT_EDGE_ANY 3'h3

`define CAT_BPS_DIV4 2'h0
`define CAT_BPS_DIV2 2'h1
`define CAT_BPS_DIV16 2'h2
`define CAT_BPS_DIV8 2'h3
`define CAT_LAST_DIV4 4'h3
`define CAT_LAST_DIV2 4'h1
`define CAT_LAST_DIV16 4'hf
`define CAT_LAST_DIV8 4'h7

`define CAT_RESP_OKAY 2'h0
`define CAT_RESP_SLVERR 2'h2

`endif

// ==== inc/cat_pkg.sv ====
// types of the timer core: control layout, pin bundle, module state
// assumes cat_regs.svh for all numeric constants
`default_nettype none
package cat_pkg;

  typedef struct packed {
    logic reload_en;
    logic clear_en;
    logic rsvd;
    logic [1:0] bps;
    logic toggle_latch;
    logic out_en;
    logic ext_dir_en;
    logic dir;
    logic run;
    logic [2:0] mode;
    logic [2:0] in_sel;
  } cat_ctrl_t;

  typedef struct packed {
    logic ext_dir;
    logic count_in;
    logic capture;
  } cat_pins_t;

  typedef enum logic [2:0] {
    CAT_SEL_NONE,
    CAT_SEL_CTRL,
    CAT_SEL_CAPTURE_RELOAD_VALUE,
    CAT_SEL_AUX,
    CAT_SEL_CORE,
    CAT_SEL_STATUS,
    CAT_SEL_MASK
  } cat_sel_t;

  typedef struct packed {
    cat_ctrl_t ctrl;
    logic [15:0] core_cnt;
    logic [15:0] aux_cnt;
    logic [15:0] capture_reload_value;
    logic [2:0] status;
    logic [2:0] mask;
    logic [3:0] div_cnt;
    logic [7:0] pre_cnt;
    cat_pins_t sync1;
    cat_pins_t sync2;
    cat_pins_t samp;
    logic aw_hold;
    logic [7:0] awaddr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cat_state_t;

endpackage
`default_nettype wire

// ==== rtl/cat_timer.sv ====
// core/auxiliary timer pair with capture/reload register, AXI4-Lite slave
// assumes pins_in are asynchronous; everything else on clk_in
//
// Overview of operation
// [R1] aux timer: 16-bit, software rw, hardware counts
// [R2] core timer: 16-bit, software rw, hardware counts
// [R3] capture/reload register: software rw, capture updates
// [R4] input select: prescale or counter edge
// [R5] mode field selects timer, counter, gated modes
// [R6] software never writes reserved mode codes
// [R7] core counts only while run bit set
// [R8] direction bit: zero up, one down
// [R9] external direction input used only when enabled
// [R10] output enable drives toggle latch to pin
// [R11] toggle latch flips on wrap, software writable
// [R12] block prescaler divides by 4,2,16,8
// [R13] reserved bit 13 reads zero
// [R14] clear enable zeroes core on capture
// [R15] reload enable reloads core from capture register
// [R16] wrap sets interrupt request flag
// [R17] external direction is input xor direction bit
// [R18] reload happens in the wrapping cycle
`include "cat_regs.svh"
`default_nettype none
module cat_timer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire cat_pkg::cat_pins_t pins_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic core_toggle_output_pin_out,
  output logic core_toggle_output_pin_oe_out,
  output logic irq_out
);

  cat_pkg::cat_state_t s_reg;
  cat_pkg::cat_state_t s_next;
  logic basic_tick;
  logic pre_tick;
  logic count_tick;
  logic core_step;
  logic dir_down;
  logic core_wrap;
  logic cap_evt;
  logic aux_step;
  logic aux_wrap;
  logic do_wr;
  cat_pkg::cat_sel_t wr_sel;
  cat_pkg::cat_sel_t rd_sel;
  logic [7:0] pre_mask;

  function automatic cat_pkg::cat_sel_t decode(input logic [7:0] addr);
    case (addr)
      `CAT_OFF_CTRL: decode = cat_pkg::CAT_SEL_CTRL;
      `CAT_OFF_CAPTURE_RELOAD_VALUE: decode = cat_pkg::CAT_SEL_CAPTURE_RELOAD_VALUE;
      `CAT_OFF_AUX: decode = cat_pkg::CAT_SEL_AUX;
      `CAT_OFF_CORE: decode = cat_pkg::CAT_SEL_CORE;
      `CAT_OFF_STATUS: decode = cat_pkg::CAT_SEL_STATUS;
      `CAT_OFF_MASK: decode = cat_pkg::CAT_SEL_MASK;
      default: decode = cat_pkg::CAT_SEL_NONE;
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  function automatic logic [3:0] div_last(input logic [1:0] bps);
    case (bps)
      `CAT_BPS_DIV4: div_last = `CAT_LAST_DIV4;
      `CAT_BPS_DIV2: div_last = `CAT_LAST_DIV2;
      `CAT_BPS_DIV16: div_last = `CAT_LAST_DIV16;
      default: div_last = `CAT_LAST_DIV8;
    endcase
  endfunction

  function automatic logic [31:0] read_mux(input cat_pkg::cat_sel_t sel,
                                           input cat_pkg::cat_state_t s);
    read_mux = 32'h0000_0000;
    case (sel)
      cat_pkg::CAT_SEL_CTRL: read_mux[15:0] = s.ctrl;
      cat_pkg::CAT_SEL_CAPTURE_RELOAD_VALUE: read_mux[15:0] = s.capture_reload_value;
      cat_pkg::CAT_SEL_AUX: read_mux[15:0] = s.aux_cnt;
      cat_pkg::CAT_SEL_CORE: read_mux[15:0] = s.core_cnt;
      cat_pkg::CAT_SEL_STATUS: read_mux[2:0] = s.status;
      cat_pkg::CAT_SEL_MASK: read_mux[2:0] = s.mask;
      default: read_mux = 32'h0000_0000;
    endcase
  endfunction

  assign s_axi_awready_out = !s_reg.aw_hold;
  assign s_axi_wready_out = !s_reg.w_hold;
  assign s_axi_bvalid_out = s_reg.bvalid;
  assign s_axi_bresp_out = s_reg.bresp;
  assign s_axi_arready_out = !s_reg.rvalid;
  assign s_axi_rvalid_out = s_reg.rvalid;
  assign s_axi_rdata_out = s_reg.rdata;
  assign s_axi_rresp_out = s_reg.rresp;
  // pin always carries the latch; the enable decides whether it leaves the block
  assign core_toggle_output_pin_out = s_reg.ctrl.toggle_latch; // R10
  assign core_toggle_output_pin_oe_out = s_reg.ctrl.out_en; // R10
  assign irq_out = |(s_reg.status & s_reg.mask);

  always_comb begin
    s_next = s_reg;
    s_next.sync1 = pins_in;
    s_next.sync2 = s_reg.sync1;

    // basic clock: non-linear divider code
    basic_tick = (s_reg.div_cnt >= div_last(s_reg.ctrl.bps)); // R12
    s_next.div_cnt = basic_tick ? 4'h0 : s_reg.div_cnt + 4'h1; // R12
    // pins are sampled on the basic clock; an edge is two samples that differ
    cap_evt = basic_tick && s_reg.sync2.capture && !s_reg.samp.capture;
    if (basic_tick) begin
      s_next.samp = s_reg.sync2;
      s_next.pre_cnt = s_reg.pre_cnt + 8'h01;
    end
    pre_mask = (8'h01 << s_reg.ctrl.in_sel) - 8'h01;
    pre_tick = basic_tick && ((s_reg.pre_cnt & pre_mask) == pre_mask); // R4

    count_tick = 1'b0;
    case (s_reg.ctrl.mode) // R5
      `CAT_MODE_TIMER: count_tick = pre_tick;
      `CAT_MODE_COUNTER: begin
        // in counter mode the input select picks the active edge
        case (s_reg.ctrl.in_sel) // R4
          `CAT_EDGE_RISE: count_tick = basic_tick && s_reg.sync2.count_in
                                       && !s_reg.samp.count_in;
          `CAT_EDGE_FALL: count_tick = basic_tick && !s_reg.sync2.count_in
                                       && s_reg.samp.count_in;
          `CAT_EDGE_ANY: count_tick = basic_tick
                                      && (s_reg.sync2.count_in != s_reg.samp.count_in);
          default: count_tick = 1'b0;
        endcase
      end
      `CAT_MODE_GATED_LOW: count_tick = pre_tick && !s_reg.samp.count_in;
      `CAT_MODE_GATED_HIGH: count_tick = pre_tick && s_reg.samp.count_in;
      // reserved codes keep the timer still
      default: count_tick = 1'b0;
    endcase

    core_step = s_reg.ctrl.run && count_tick; // R7
    dir_down = s_reg.ctrl.ext_dir_en ? (s_reg.samp.ext_dir ^ s_reg.ctrl.dir) // R9 R17
                                     : s_reg.ctrl.dir; // R8
    core_wrap = core_step && (dir_down ? (s_reg.core_cnt == 16'h0000)
                                       : (s_reg.core_cnt == `CAT_COUNT_MAX)); // R16
    aux_step = basic_tick && s_reg.ctrl.run;
    aux_wrap = aux_step && (s_reg.aux_cnt == `CAT_COUNT_MAX);

    if (core_step) begin
      if (core_wrap && s_reg.ctrl.reload_en) begin
        s_next.core_cnt = s_reg.capture_reload_value; // R15 R18
      end else if (dir_down) begin
        s_next.core_cnt = s_reg.core_cnt - 16'h0001; // R2 R8
      end else begin
        s_next.core_cnt = s_reg.core_cnt + 16'h0001; // R2 R8
      end
    end
    if (cap_evt && s_reg.ctrl.clear_en) begin
      s_next.core_cnt = 16'h0000; // R14
    end
    if (core_wrap) begin
      s_next.ctrl.toggle_latch = !s_reg.ctrl.toggle_latch; // R11
    end
    if (aux_step) begin
      s_next.aux_cnt = s_reg.aux_cnt + 16'h0001; // R1
    end
    if (cap_evt) begin
      s_next.capture_reload_value = s_reg.aux_cnt; // R3
    end
    s_next.status = s_reg.status | {cap_evt, aux_wrap, core_wrap}; // R16

    // write channel: address and data accepted in either order
    if (s_axi_awvalid_in && !s_reg.aw_hold) begin
      s_next.aw_hold = 1'b1;
      s_next.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !s_reg.w_hold) begin
      s_next.w_hold = 1'b1;
      s_next.wdata = s_axi_wdata_in;
      s_next.wstrb = s_axi_wstrb_in;
    end
    if (s_reg.bvalid && s_axi_bready_in) begin
      s_next.bvalid = 1'b0;
    end
    do_wr = s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid;
    wr_sel = decode(s_reg.awaddr);
    if (do_wr) begin
      s_next.aw_hold = 1'b0;
      s_next.w_hold = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = (wr_sel == cat_pkg::CAT_SEL_NONE) ? `CAT_RESP_SLVERR : `CAT_RESP_OKAY;
      // software writes override same-cycle hardware updates of the value, except in status where a same-cycle event still sets its bit
      case (wr_sel)
        cat_pkg::CAT_SEL_CTRL: begin
          s_next.ctrl = merge16(s_reg.ctrl, s_reg.wdata, s_reg.wstrb); // R11
          s_next.ctrl.rsvd = 1'b0; // R13
        end
        cat_pkg::CAT_SEL_CAPTURE_RELOAD_VALUE: s_next.capture_reload_value = merge16(s_reg.capture_reload_value, s_reg.wdata,
                                                          s_reg.wstrb); // R3
        cat_pkg::CAT_SEL_AUX: s_next.aux_cnt = merge16(s_reg.aux_cnt, s_reg.wdata,
                                                        s_reg.wstrb); // R1
        cat_pkg::CAT_SEL_CORE: s_next.core_cnt = merge16(s_reg.core_cnt, s_reg.wdata,
                                                          s_reg.wstrb); // R2
        cat_pkg::CAT_SEL_STATUS: begin
          // write-one-to-clear, a same-cycle event still sets its bit
          if (s_reg.wstrb[0]) begin
            s_next.status = (s_reg.status & ~s_reg.wdata[2:0])
                            | {cap_evt, aux_wrap, core_wrap};
          end
        end
        cat_pkg::CAT_SEL_MASK: begin
          if (s_reg.wstrb[0]) begin
            s_next.mask = s_reg.wdata[2:0];
          end
        end
        default: s_next.bresp = `CAT_RESP_SLVERR;
      endcase
    end

    rd_sel = decode(s_axi_araddr_in);
    if (s_axi_arvalid_in && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = read_mux(rd_sel, s_reg); // R13
      s_next.rresp = (rd_sel == cat_pkg::CAT_SEL_NONE) ? `CAT_RESP_SLVERR : `CAT_RESP_OKAY;
    end else if (s_reg.rvalid && s_axi_rready_in) begin
      s_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
      s_reg.ctrl <= cat_pkg::cat_ctrl_t'(`CAT_RST_CTRL);
      s_reg.capture_reload_value <= `CAT_RST_CAPTURE_RELOAD_VALUE;
      s_reg.core_cnt <= `CAT_RST_COUNT;
      s_reg.aux_cnt <= `CAT_RST_COUNT;
    end else if (clk_en_in) begin
      s_reg <= s_next;
    end
  end

  logic core_wr;
  logic ctrl_wr;
  logic capture_reload_value_wr;
  logic aux_wr;
  logic status_wr;
  assign core_wr = do_wr && (wr_sel == cat_pkg::CAT_SEL_CORE);
  assign ctrl_wr = do_wr && (wr_sel == cat_pkg::CAT_SEL_CTRL);
  assign capture_reload_value_wr = do_wr && (wr_sel == cat_pkg::CAT_SEL_CAPTURE_RELOAD_VALUE);
  assign aux_wr = do_wr && (wr_sel == cat_pkg::CAT_SEL_AUX);
  assign status_wr = do_wr && (wr_sel == cat_pkg::CAT_SEL_STATUS);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  AST_CORE_HOLD: assert property ( // R7
    (clk_en_in && !s_reg.ctrl.run && !core_wr && !(cap_evt && s_reg.ctrl.clear_en))
    |=> (s_reg.core_cnt == $past(s_reg.core_cnt)))
    else $error("core timer moved while stopped");

  AST_COUNT_UP: assert property ( // R8
    (clk_en_in && core_step && !dir_down && !core_wrap && !core_wr && !cap_evt)
    |=> (s_reg.core_cnt == $past(s_reg.core_cnt) + 16'h0001))
    else $error("core timer did not count up");

  AST_EXT_DOWN: assert property ( // R17
    (clk_en_in && core_step && s_reg.ctrl.ext_dir_en && s_reg.samp.ext_dir
     && !s_reg.ctrl.dir && !core_wrap && !core_wr && !cap_evt)
    |=> (s_reg.core_cnt == $past(s_reg.core_cnt) - 16'h0001))
    else $error("external direction not applied");

  AST_DIR_INTERNAL: assert property ( // R9
    !s_reg.ctrl.ext_dir_en |-> (dir_down == s_reg.ctrl.dir))
    else $error("external direction used while disabled");

  AST_TOGGLE: assert property ( // R11
    (clk_en_in && core_wrap && !ctrl_wr)
    |=> (s_reg.ctrl.toggle_latch != $past(s_reg.ctrl.toggle_latch))
        ##0 (core_toggle_output_pin_out == s_reg.ctrl.toggle_latch))
    else $error("toggle latch did not flip on wrap");

  AST_RELOAD: assert property ( // R18
    (clk_en_in && core_wrap && s_reg.ctrl.reload_en && !core_wr && !cap_evt)
    |=> (s_reg.core_cnt == $past(s_reg.capture_reload_value)))
    else $error("core timer not reloaded on wrap");

  AST_CLEAR: assert property ( // R14
    (clk_en_in && cap_evt && s_reg.ctrl.clear_en && !core_wr)
    |=> (s_reg.core_cnt == 16'h0000))
    else $error("core timer not cleared on capture");

  AST_CAPTURE: assert property ( // R3
    (clk_en_in && cap_evt && !capture_reload_value_wr) |=> (s_reg.capture_reload_value == $past(s_reg.aux_cnt)))
    else $error("capture value wrong");

  AST_WRAP_FLAG: assert property ( // R16
    (clk_en_in && core_wrap) |=> s_reg.status[`CAT_ST_CORE] ##1 1'b1)
    else $error("wrap did not set its flag");

  AST_DIV2: assert property ( // R12
    (basic_tick && clk_en_in && s_reg.ctrl.bps == `CAT_BPS_DIV2 && !ctrl_wr)
    ##1 (clk_en_in && !basic_tick && !ctrl_wr) ##1 clk_en_in |-> basic_tick)
    else $error("divide by two prescaler wrong");

  AST_GATE_LOW: assert property ( // R5
    (s_reg.ctrl.mode == `CAT_MODE_GATED_LOW && s_reg.samp.count_in) |-> !core_step)
    else $error("gated timer counted with gate closed");

  AST_RSVD: assert property ( // R13
    s_reg.ctrl.rsvd == 1'b0)
    else $error("reserved control bit set");

  AST_AUX_WRITE: assert property ( // R1
    (clk_en_in && aux_wr && s_reg.wstrb[1:0] == 2'b11)
    |=> (s_reg.aux_cnt == $past(s_reg.wdata[15:0])))
    else $error("aux timer write lost");

  AST_CORE_WRITE: assert property ( // R2
    (clk_en_in && core_wr && s_reg.wstrb[1:0] == 2'b11)
    |=> (s_reg.core_cnt == $past(s_reg.wdata[15:0])))
    else $error("core timer write lost");

  AST_CAPTURE_RELOAD_VALUE_WRITE: assert property ( // R3
    (clk_en_in && capture_reload_value_wr && s_reg.wstrb[1:0] == 2'b11)
    |=> (s_reg.capture_reload_value == $past(s_reg.wdata[15:0])))
    else $error("capture/reload write lost");

  // software owns the latch in a write cycle, hardware toggles elsewhere
  AST_CTRL_WRITE: assert property ( // R11 R13
    (clk_en_in && ctrl_wr && s_reg.wstrb[1:0] == 2'b11)
    |=> (s_reg.ctrl == ($past(s_reg.wdata[15:0]) & `CAT_CTRL_WMASK)))
    else $error("control write not stored");

  AST_COUNT_DOWN: assert property ( // R8
    (clk_en_in && core_step && dir_down && !core_wrap && !core_wr && !cap_evt)
    |=> (s_reg.core_cnt == $past(s_reg.core_cnt) - 16'h0001))
    else $error("core timer did not count down");

  // only a status write may drop a flag; set wins inside that write
  AST_FLAG_STICKY: assert property ( // R16
    (clk_en_in && s_reg.status[`CAT_ST_CORE] && !status_wr) |=> s_reg.status[`CAT_ST_CORE])
    else $error("wrap flag lost without a clear");

  // a low enable freezes everything, bus handshake state included
  AST_FREEZE: assert property (
    !clk_en_in |=> (s_reg == $past(s_reg)))
    else $error("state moved while clock enable low");

  COV_RELOAD: cover property (core_wrap && s_reg.ctrl.reload_en);
  COV_CAPTURE_CLEAR: cover property (cap_evt && s_reg.ctrl.clear_en);
  COV_IRQ: cover property (!irq_out ##1 irq_out);
  COV_READ: cover property (s_axi_rvalid_out && s_axi_rready_in);
  COV_COUNTER_EDGE: cover property (s_reg.ctrl.mode == `CAT_MODE_COUNTER && core_step);

endmodule
`default_nettype wire

// ==== verif/cat_tb.sv ====
// self-checking bench for the timer core: registers, counting, wrap, capture
// assumes cat_timer, cat_pkg and cat_regs.svh; bench is the only bus master
`include "cat_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] a_ctl = `CAT_OFF_CTRL;
  localparam logic [7:0] a_cap = `CAT_OFF_CAPTURE_RELOAD_VALUE;
  localparam logic [7:0] a_aux = `CAT_OFF_AUX;
  localparam logic [7:0] a_core = `CAT_OFF_CORE;
  localparam logic [7:0] a_st = `CAT_OFF_STATUS;
  localparam logic [7:0] a_msk = `CAT_OFF_MASK;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic clk_en = 1'b1;
  cat_pkg::cat_pins_t pins = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, pin, oe, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  cat_timer dut (.clk_in(clk_in), .rst_in(rst_in), .clk_en_in(clk_en), .pins_in(pins),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .core_toggle_output_pin_out(pin),
    .core_toggle_output_pin_oe_out(oe), .irq_out(irq));

  always #5 clk_in = ~clk_in;

  // generous ceiling: the whole sequence needs under two thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bus timing fixes the read instant only to within one count tick
  task automatic near(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] tol);
    logic [15:0] d;
    d = got - exp + tol;
    checked++;
    if ((d <= 16'(tol * 2)) !== 1'b1) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ready and valid sampled at the falling edge, so the handshake is known at the next rise
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk_in);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge clk_in);
      aw_ok = awvalid & awready;
      w_ok = wvalid & wready;
      b_ok = bvalid;
      resp = bresp;
      @(posedge clk_in);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_ok, r_ok;
    @(posedge clk_in);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge clk_in);
      ar_ok = arvalid & arready;
      r_ok = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clk_in);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic t_reset();
    logic [7:0] offs [4] = '{a_ctl, a_cap, a_aux, a_core};
    logic [31:0] d;
    logic [1:0] r;
    foreach (offs[i]) begin
      axr(offs[i], d, r);
      chk(d, 32'h0000_0000);
    end
    axr(8'h40, d, r);
    chk({30'h0, r}, {30'h0, `CAT_RESP_SLVERR});
    axw(8'h04, 32'h0000_1234, r);
    chk({30'h0, r}, {30'h0, `CAT_RESP_SLVERR});
    @(negedge clk_in);
    chk({29'h0, irq, pin, oe}, 32'h0000_0000);
  endtask

  task automatic t_regs();
    logic [7:0] offs [3] = '{a_aux, a_core, a_cap};
    logic [31:0] d;
    logic [1:0] r;
    foreach (offs[i]) begin
      wr(offs[i], 32'h0000_a5c3);
      axr(offs[i], d, r);
      chk(d, 32'h0000_a5c3);
      chk({30'h0, r}, {30'h0, `CAT_RESP_OKAY});
    end
    // run bit left clear so nothing counts during the readback
    wr(a_ctl, 32'h0000_ef9a);
    axr(a_ctl, d, r);
    chk(d, 32'h0000_cf9a);
    @(negedge clk_in);
    chk({30'h0, pin, oe}, 32'h0000_0003);
    wr(a_ctl, 32'h0000_0000);
    @(negedge clk_in);
    chk({31'h0, oe}, 32'h0000_0000);
  endtask

  task automatic run_chk(input logic [31:0] ctl, input logic ext, input logic lvl, input int n,
                         input logic tog, input logic [15:0] d);
    logic [31:0] got;
    logic [1:0] r;
    pins.ext_dir <= ext;
    pins.count_in <= lvl;
    wr(a_ctl, ctl & 32'hffff_ffbf);
    // let the basic-clock divider settle on the new setting while stopped
    repeat (16) @(posedge clk_in);
    wr(a_core, 32'h0000_1000);
    wr(a_ctl, ctl);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      if (tog) pins.count_in <= i[3];
    end
    axr(a_core, got, r);
    near(got[15:0], 16'h1000 + d, 16'h0002);
  endtask

  task automatic t_count();
    run_chk(32'h0000_0800, 1'b0, 1'b0, 62, 1'b0, 16'h0000);
    run_chk(32'h0000_0840, 1'b1, 1'b0, 62, 1'b0, 16'h0020);
    run_chk(32'h0000_08c0, 1'b0, 1'b0, 62, 1'b0, 16'hffe0);
    run_chk(32'h0000_0940, 1'b1, 1'b0, 62, 1'b0, 16'hffe0);
    run_chk(32'h0000_09c0, 1'b1, 1'b0, 62, 1'b0, 16'h0020);
    run_chk(32'h0000_0850, 1'b0, 1'b1, 62, 1'b0, 16'h0000);
    run_chk(32'h0000_0858, 1'b0, 1'b1, 62, 1'b0, 16'h0020);
    run_chk(32'h0000_0849, 1'b0, 1'b0, 80, 1'b1, 16'h0005);
    run_chk(32'h0000_084a, 1'b0, 1'b0, 80, 1'b1, 16'h0004);
  endtask

  task automatic t_wrap();
    logic [31:0] d;
    logic [1:0] r;
    wr(a_ctl, 32'h0000_0800);
    wr(a_msk, 32'h0000_0001);
    wr(a_core, 32'h0000_fff0);
    wr(a_ctl, 32'h0000_0a40);
    repeat (62) @(posedge clk_in);
    axr(a_core, d, r);
    near(d[15:0], 16'h0010, 16'h0002);
    @(negedge clk_in);
    chk({29'h0, irq, pin, oe}, 32'h0000_0007);
    axr(a_st, d, r);
    chk({31'h0, d[0]}, 32'h0000_0001);
    axr(a_ctl, d, r);
    chk(d, 32'h0000_0e40);
    // stopping with bit 10 low also clears the latch from software
    wr(a_ctl, 32'h0000_0800);
    axr(a_ctl, d, r);
    chk(d, 32'h0000_0800);
    wr(a_st, 32'h0000_0001);
    @(negedge clk_in);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  task automatic t_reload();
    logic [31:0] d;
    logic [1:0] r;
    wr(a_ctl, 32'h0000_0800);
    wr(a_cap, 32'h0000_8000);
    wr(a_core, 32'h0000_fff0);
    wr(a_ctl, 32'h0000_8840);
    repeat (62) @(posedge clk_in);
    axr(a_core, d, r);
    near(d[15:0], 16'h8010, 16'h0002);
  endtask

  task automatic t_capture();
    logic [31:0] d;
    logic [1:0] r;
    wr(a_ctl, 32'h0000_4840);
    wr(a_aux, 32'h0000_0500);
    wr(a_core, 32'h0000_0300);
    pins.capture <= 1'b1;
    repeat (12) @(posedge clk_in);
    axr(a_cap, d, r);
    near(d[15:0], 16'h0505, 16'h0004);
    axr(a_core, d, r);
    near(d[15:0], 16'h0005, 16'h0005);
    axr(a_st, d, r);
    chk({31'h0, d[2]}, 32'h0000_0001);
    pins.capture <= 1'b0;
  endtask

  task automatic t_prescale();
    logic [1:0] bps [4] = '{2'b01, 2'b00, 2'b11, 2'b10};
    logic [15:0] f [4] = '{16'h0002, 16'h0004, 16'h0008, 16'h0010};
    foreach (bps[i])
      run_chk({19'h0, bps[i], 11'h040}, 1'b0, 1'b0, 62, 1'b0, 16'h0040 / f[i]);
  endtask

  // 40 frozen cycles must cost exactly their 20 ticks of the divide-by-two count
  task automatic t_freeze();
    logic [31:0] d;
    logic [1:0] r;
    wr(a_ctl, 32'h0000_0800);
    wr(a_core, 32'h0000_1000);
    wr(a_ctl, 32'h0000_0840);
    repeat (30) @(posedge clk_in);
    clk_en <= 1'b0;
    repeat (40) @(posedge clk_in);
    clk_en <= 1'b1;
    repeat (30) @(posedge clk_in);
    axr(a_core, d, r);
    near(d[15:0], 16'h101f, 16'h0002);
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_regs();
    t_count();
    t_wrap();
    t_reload();
    t_capture();
    t_prescale();
    t_freeze();
    summarize();
  end
endmodule
`default_nettype wire
